// *** inc/pzr_pkg.sv ***
// package: port0 register map, reset values and pin carriers
package pzr_pkg;
    // ****************************************
    // register indices (byte address is 4x)
    // ****************************************
    localparam logic [7:0] IDX_DATA = 8'h80;
    localparam logic [7:0] IDX_OE = 8'h91;
    localparam logic [7:0] IDX_FSEL = 8'h93;
    localparam logic [7:0] IDX_PWM1ST = 8'hA6;
    localparam logic [7:0] IDX_DIE = 8'hAF;
    localparam logic [7:0] IDX_PWM2ND = 8'hB6;
    localparam logic [7:0] IDX_PWM3RD = 8'hB7;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_OE = 8'h00;
    localparam logic [7:0] RST_FSEL = 8'h05;
    localparam logic [7:0] RST_PWM = 8'h00;
    localparam logic [7:0] RST_DIE = 8'h00;
    // ****************************************
    // field positions
    // ****************************************
    localparam int FSEL_SERIAL = 7;
    localparam int THIRD_SDA_SEL = 7;
    localparam int THIRD_SCL_SEL = 6;
    // pins that hand over to the adc when the input gate is 0
    localparam logic [7:0] ADC_PIN_MASK = 8'hB8;
    // ****************************************
    // pin drive carrier
    // ****************************************
    typedef struct packed {
        logic out;
        logic oe_n;
        logic pu;
    } pzr_drive_s;
    // alternate function request for one pin
    typedef struct packed {
        logic en;
        logic val;
        logic pu;
    } pzr_alt_s;
endpackage : pzr_pkg

// *** src/pzr_pin_cell.sv ***
// single pin drive cell: gpio versus alternate function
`timescale 1ns/1ns
`default_nettype none
module pzr_pin_cell (
    input wire logic oe,
    input wire logic data,
    input wire pzr_pkg::pzr_alt_s alt,
    output pzr_pkg::pzr_drive_s drv
);
    always_comb begin
        drv.out = data;
        drv.oe_n = 1'b1;
        drv.pu = 1'b0;
        if (alt.en) begin
            // data bit ignored under an alternate function
            drv.out = alt.val; // [R14]
            if (oe) begin
                drv.oe_n = 1'b0; // [R14]
            end else begin
                // open drain: pull low only, release for high
                drv.out = 1'b0;
                drv.oe_n = alt.val; // [R14]
                drv.pu = alt.pu; // [R15]
            end
        end else if (oe) begin
            drv.oe_n = 1'b0; // [R2]
        end else begin
            drv.pu = data; // [R1]
        end
    end
endmodule : pzr_pin_cell
`default_nettype wire

// *** src/pzr_port0.sv ***
// port0 pins, register file and alternate function routing
`timescale 1ns/1ns
`default_nettype none
// How it works
// [R1] input mode: pin undriven, pull-up follows data bit
// [R2] output mode: push-pull to data bit, pull-up off, input unused
// [R3] data register read/write, reset zero, also pull-up control
// [R4] output-enable register, one bit per pin, reset zero
// [R5] input gate: 0 blocks input, pins 7,5,4,3 go to adc
// [R6] serial select moves transmit/receive between port3 and port1/port0
// [R7] first route bits 7..4 put pwm_one on P1.2,P0.6,P0.4,P0.2
// [R8] first route bits 3..0 place pwm zero outputs on P3.6,P3.5,P0.4,P0.3
// [R9] second route bits 7..4 put pwm_four on P3.6,P1.5,P0.4,P0.0
// [R10] second route bits 3..0 place pwm_three and pwm_two
// [R11] third route bits 5..0 place pwm_six and pwm_five
// [R12] i2c data select: P3.5 when 0, P1.6 when 1
// [R13] i2c clock select: P1.3 when 0, P0.2 when 1
// [R14] routed pwm: open drain if enable 0, push-pull if 1
// [R15] i2c clock pin: open drain with pull-up, or push-pull
// [R16] fixed priority picks one source per pin
module pzr_port0 #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe_n,
    output logic [7:0] pad_pu,
    output logic [7:0] port_zero_digital_in,
    output logic [7:0] adc_pin_select,
    input wire logic pwm_zero_positive,
    input wire logic pwm_zero_negative,
    input wire logic pwm_one,
    input wire logic pwm_two,
    input wire logic pwm_three,
    input wire logic pwm_four,
    input wire logic pwm_five,
    input wire logic pwm_six,
    input wire logic i2c_clock_out,
    input wire logic i2c_master_en,
    input wire logic port3_rx_in,
    output logic uart_rx,
    output logic [7:0] port1_alt_en,
    output logic [7:0] port1_alt_val,
    output logic [7:0] port3_alt_en,
    output logic [7:0] port3_alt_val,
    output logic serial_pin_select,
    output logic i2c_data_pin_select,
    output logic i2c_clock_pin_select
);
    // ****************************************
    // apb decode
    // ****************************************
    logic [7:0] data_q;
    logic [7:0] oe_q;
    logic [7:0] fsel_q;
    logic [7:0] first_q;
    logic [7:0] die_q;
    logic [7:0] second_q;
    logic [7:0] third_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    wire [ADDR_W-1:0] idx_full = paddr >> 2;
    wire [7:0] idx = idx_full[7:0];
    wire word_ok = (paddr[1:0] == 2'b00) && (idx_full[ADDR_W-1:8] == '0);
    wire hit_data = word_ok && (idx == pzr_pkg::IDX_DATA);
    wire hit_oe = word_ok && (idx == pzr_pkg::IDX_OE);
    wire hit_fsel = word_ok && (idx == pzr_pkg::IDX_FSEL);
    wire hit_first = word_ok && (idx == pzr_pkg::IDX_PWM1ST);
    wire hit_die = word_ok && (idx == pzr_pkg::IDX_DIE);
    wire hit_second = word_ok && (idx == pzr_pkg::IDX_PWM2ND);
    wire hit_third = word_ok && (idx == pzr_pkg::IDX_PWM3RD);
    wire hit_any = hit_data | hit_oe | hit_fsel | hit_first | hit_die | hit_second | hit_third;
    // setup phase computes the answer, access phase presents it
    wire setup = psel && !penable && !pready_q;
    // writes land on the access edge, when pready is seen high
    wire wr = psel && penable && pready_q && pwrite && !pslverr_q;
    wire [7:0] wb = pwdata[7:0];
    wire [7:0] rd_sel =
        ({8{hit_data}} & data_q) |
        ({8{hit_oe}} & oe_q) |
        ({8{hit_fsel}} & fsel_q) |
        ({8{hit_first}} & first_q) |
        ({8{hit_die}} & die_q) |
        ({8{hit_second}} & second_q) |
        ({8{hit_third}} & third_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && !hit_any;
            prdata_q <= (setup && !pwrite) ? {24'h00_0000, rd_sel} : 32'h0000_0000;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= pzr_pkg::RST_DATA; // [R3]
            oe_q <= pzr_pkg::RST_OE; // [R4]
            fsel_q <= pzr_pkg::RST_FSEL;
            first_q <= pzr_pkg::RST_PWM;
            die_q <= pzr_pkg::RST_DIE; // [R5]
            second_q <= pzr_pkg::RST_PWM;
            third_q <= pzr_pkg::RST_PWM;
        end else begin
            if (wr && hit_data) data_q <= wb; // [R3]
            if (wr && hit_oe) oe_q <= wb; // [R4]
            if (wr && hit_fsel) fsel_q <= wb;
            if (wr && hit_first) first_q <= wb;
            if (wr && hit_die) die_q <= wb; // [R5]
            if (wr && hit_second) second_q <= wb;
            if (wr && hit_third) third_q <= wb;
        end
    end

    // ****************************************
    // port0 routing, earlier term wins
    // ****************************************
    wire scl_on_p02 = i2c_master_en && third_q[pzr_pkg::THIRD_SCL_SEL]; // [R13]
    wire scl_on_p13 = i2c_master_en && !third_q[pzr_pkg::THIRD_SCL_SEL]; // [R13]
    pzr_pkg::pzr_alt_s alt0 [8];
    // i2c clock outranks pwm so a bus is never corrupted
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            alt0[i] = '0;
        end
        alt0[0] = '{second_q[4], pwm_four, 1'b0}; // [R9]
        alt0[1] = '{third_q[0], pwm_five, 1'b0}; // [R11]
        if (scl_on_p02) begin
            alt0[2] = '{1'b1, i2c_clock_out, 1'b1}; // [R15] [R16]
        end else begin
            alt0[2] = '{first_q[4], pwm_one, 1'b0}; // [R7]
        end
        if (first_q[0]) begin
            alt0[3] = '{1'b1, pwm_zero_positive, 1'b0}; // [R8] [R16]
        end else begin
            alt0[3] = '{third_q[3], pwm_six, 1'b0}; // [R11]
        end
        if (first_q[1]) begin
            alt0[4] = '{1'b1, pwm_zero_negative, 1'b0}; // [R8] [R16]
        end else if (first_q[5]) begin
            alt0[4] = '{1'b1, pwm_one, 1'b0}; // [R7]
        end else begin
            alt0[4] = '{second_q[5], pwm_four, 1'b0}; // [R9]
        end
        if (first_q[6]) begin
            alt0[6] = '{1'b1, pwm_one, 1'b0}; // [R7] [R16]
        end else begin
            alt0[6] = '{third_q[1], pwm_five, 1'b0}; // [R11]
        end
        alt0[7] = '{third_q[4], pwm_six, 1'b0}; // [R11]
    end

    pzr_pkg::pzr_drive_s drv [8];
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pin
            pzr_pin_cell u_cell (
                .oe(oe_q[g]),
                .data(data_q[g]),
                .alt(alt0[g]),
                .drv(drv[g])
            );
        end
    endgenerate

    // ****************************************
    // port1 and port3 routing requests
    // ****************************************
    logic [7:0] p1_en_d;
    logic [7:0] p1_val_d;
    logic [7:0] p3_en_d;
    logic [7:0] p3_val_d;
    always_comb begin
        p1_en_d = 8'h00;
        p1_val_d = 8'h00;
        p3_en_d = 8'h00;
        p3_val_d = 8'h00;
        p1_en_d[0] = second_q[2]; // [R10]
        p1_val_d[0] = pwm_three;
        p1_en_d[1] = second_q[0]; // [R10]
        p1_val_d[1] = pwm_two;
        p1_en_d[2] = first_q[7]; // [R7]
        p1_val_d[2] = pwm_one;
        p1_en_d[3] = scl_on_p13 || third_q[5]; // [R11] [R13]
        p1_val_d[3] = scl_on_p13 ? i2c_clock_out : pwm_six; // [R16]
        p1_en_d[4] = third_q[2]; // [R11]
        p1_val_d[4] = pwm_five;
        p1_en_d[5] = second_q[6]; // [R9]
        p1_val_d[5] = pwm_four;
        p3_en_d[4] = second_q[3]; // [R10]
        p3_val_d[4] = pwm_three;
        p3_en_d[5] = first_q[2]; // [R8]
        p3_val_d[5] = pwm_zero_positive;
        p3_en_d[6] = first_q[3] || second_q[7] || second_q[1]; // [R8] [R9] [R10]
        if (first_q[3]) begin
            p3_val_d[6] = pwm_zero_negative; // [R16]
        end else if (second_q[7]) begin
            p3_val_d[6] = pwm_four;
        end else begin
            p3_val_d[6] = pwm_two;
        end
    end

    // ****************************************
    // output registers
    // ****************************************
    logic [7:0] out_d;
    logic [7:0] oen_d;
    logic [7:0] pu_d;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            out_d[i] = drv[i].out;
            oen_d[i] = drv[i].oe_n;
            pu_d[i] = drv[i].pu;
        end
    end
    // input path gated off by the gate bit and by output mode
    wire [7:0] din_d = pad_in & die_q & ~oe_q; // [R2] [R5]
    wire rx_from_p02 = fsel_q[pzr_pkg::FSEL_SERIAL]; // [R6]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out <= 8'h00;
            pad_oe_n <= 8'hFF;
            pad_pu <= 8'h00;
            port_zero_digital_in <= 8'h00;
            adc_pin_select <= 8'h00;
            uart_rx <= 1'b1;
            port1_alt_en <= 8'h00;
            port1_alt_val <= 8'h00;
            port3_alt_en <= 8'h00;
            port3_alt_val <= 8'h00;
            serial_pin_select <= 1'b0;
            i2c_data_pin_select <= 1'b0;
            i2c_clock_pin_select <= 1'b0;
        end else begin
            pad_out <= out_d;
            pad_oe_n <= oen_d; // [R1] [R2]
            pad_pu <= pu_d; // [R1]
            port_zero_digital_in <= din_d;
            adc_pin_select <= ~die_q & pzr_pkg::ADC_PIN_MASK; // [R5]
            uart_rx <= rx_from_p02 ? din_d[2] : port3_rx_in; // [R6]
            port1_alt_en <= p1_en_d;
            // a disabled route shows 0, not a stale source level
            port1_alt_val <= p1_val_d & p1_en_d;
            port3_alt_en <= p3_en_d;
            port3_alt_val <= p3_val_d & p3_en_d;
            serial_pin_select <= fsel_q[pzr_pkg::FSEL_SERIAL]; // [R6]
            i2c_data_pin_select <= third_q[pzr_pkg::THIRD_SDA_SEL]; // [R12]
            i2c_clock_pin_select <= third_q[pzr_pkg::THIRD_SCL_SEL]; // [R13]
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
endmodule : pzr_port0
`default_nettype wire

// *** verif/pzr_port0_sva.sv ***
// checker: port0 bus answer, input gate and receive routing properties
`timescale 1ns/1ns
`default_nettype none
module pzr_port0_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic [7:0] pad_in,
    input wire logic [7:0] pad_oe_n,
    input wire logic [7:0] pad_pu,
    input wire logic [7:0] port_zero_digital_in,
    input wire logic [7:0] adc_pin_select,
    input wire logic port3_rx_in,
    input wire logic uart_rx,
    input wire logic serial_pin_select
);
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no answer in access cycle");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_err_nodata: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer carries data");
    chk_adc_pins: assert property ((adc_pin_select & 8'h47) == 8'h00)
        else $error("adc handover on wrong pin");
    chk_adc_nodin: assert property ((adc_pin_select & port_zero_digital_in) == 8'h00)
        else $error("adc pin still feeds digital input");
    chk_din_pad: assert property ((port_zero_digital_in & ~$past(pad_in)) == 8'h00)
        else $error("digital input high on low pin");
    // first edge after release still shows the reset value of the receive flop
    chk_rx_port3: assert property ($past(presetn) && !serial_pin_select &&
        !$past(serial_pin_select) |-> uart_rx == $past(port3_rx_in))
        else $error("receive not taken from port3");
    chk_reset_idle: assert property ($rose(presetn) |-> pad_oe_n == 8'hFF && pad_pu == 8'h00)
        else $error("pins not idle inputs after reset");
    cov_error: cover property (pslverr);
    cov_adc: cover property (adc_pin_select != 8'h00);
    cov_rx_sel: cover property (serial_pin_select && pready);
endmodule : pzr_port0_sva
bind pzr_port0 pzr_port0_sva i_pzr_port0_sva (.pclk, .presetn, .psel, .penable, .pready,
    .pslverr, .prdata, .pad_in, .pad_oe_n, .pad_pu, .port_zero_digital_in, .adc_pin_select,
    .port3_rx_in, .uart_rx, .serial_pin_select);
`default_nettype wire

// *** verif/pzr_pad_model.sv ***
// partner: external circuitry resolving port0 pin levels
`timescale 1ns/1ns
`default_nettype none
module pzr_pad_model (
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe_n,
    input wire logic [7:0] pad_pu,
    input wire logic [7:0] ext,
    output logic [7:0] pad_in
);
    // driven pins win; undriven pins read the pull-up or the outside level
    assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & (pad_pu | ext));
endmodule : pzr_pad_model
`default_nettype wire

// *** verif/tb_pzr_port0.sv ***
// testbench: port0 registers, pin modes and alternate routing
`timescale 1ns/1ns
`default_nettype none
module tb_pzr_port0;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, r, seed = 32'h448F;
    logic pready, pslverr, uart_rx, serial_pin_select, i2c_data_pin_select, i2c_clock_pin_select;
    logic [7:0] pad_in, pad_out, pad_oe_n, pad_pu, port_zero_digital_in, adc_pin_select;
    logic [7:0] port1_alt_en, port1_alt_val, port3_alt_en, port3_alt_val;
    logic [7:0] ext = 8'h0, pwm = 8'h0, eo, en, ep, e1, v1, e3, v3, tk, oe, gt, pin;
    logic i2c_clock_out = 1'h0, i2c_master_en = 1'h0, port3_rx_in = 1'h0, err;
    int failures = 0, checks_done = 0;
    logic [7:0] ia [7] = '{8'h80, 8'h91, 8'h93, 8'hA6, 8'hAF, 8'hB6, 8'hB7};
    logic [7:0] mdl [7] = '{8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
    // {model slot, bit, port, pin, source}, shared pins listed in priority order
    logic [19:0] rt [22] = '{20'h31041, 20'h35042, 20'h55045, 20'h30030, 20'h63037, 20'h36062,
        20'h61066, 20'h34022, 20'h54005, 20'h64077, 20'h60016, 20'h37122, 20'h33361, 20'h57365,
        20'h51363, 20'h32350, 20'h56155, 20'h53344, 20'h52104, 20'h50113, 20'h65137, 20'h62146};
    always #2 pclk = ~pclk;
    pzr_port0 i_pzr_port0 (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pad_in, .pad_out, .pad_oe_n, .pad_pu, .port_zero_digital_in,
        .adc_pin_select, .pwm_zero_positive(pwm[0]), .pwm_zero_negative(pwm[1]),
        .pwm_one(pwm[2]), .pwm_two(pwm[3]), .pwm_three(pwm[4]), .pwm_four(pwm[5]),
        .pwm_five(pwm[6]), .pwm_six(pwm[7]), .i2c_clock_out, .i2c_master_en, .port3_rx_in,
        .uart_rx, .port1_alt_en, .port1_alt_val, .port3_alt_en, .port3_alt_val,
        .serial_pin_select, .i2c_data_pin_select, .i2c_clock_pin_select);
    pzr_pad_model i_pzr_pad_model (.pad_out, .pad_oe_n, .pad_pu, .ext, .pad_in);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input int k);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {2'h0, a, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n == 20) failures++;
        if (w && k >= 0) mdl[k] = wd[7:0];
    endtask : apb
    task automatic rdchk(input int k);
        apb(1'h0, ia[k], 32'h0, k);
        chk("read", rd, {24'h00_0000, mdl[k]});
        chk("read_err", err, 1'h0);
    endtask : rdchk
    // first enabled source on a pin wins
    task automatic ovr(input int pt, input int pn, input logic s, input logic scl);
        if (pt == 0 && !tk[pn]) begin
            tk[pn] = 1'h1;
            eo[pn] = oe[pn] & s;
            en[pn] = !oe[pn] & s;
            ep[pn] = scl & !oe[pn];
        end else if (pt == 1 && !e1[pn]) begin
            e1[pn] = 1'h1;
            v1[pn] = s;
        end else if (pt == 3 && !e3[pn]) begin
            e3[pn] = 1'h1;
            v3[pn] = s;
        end
    endtask : ovr
    task automatic check_all();
        oe = mdl[1];
        gt = mdl[4];
        // the pad level follows the data bit even while the driver is off
        eo = mdl[0];
        en = ~oe;
        ep = mdl[0] & ~oe;
        {tk, e1, v1, e3, v3} = 40'h0;
        if (i2c_master_en) ovr(mdl[6][6] ? 0 : 1, mdl[6][6] ? 2 : 3, i2c_clock_out, 1'h1);
        foreach (rt[j]) begin
            if (mdl[rt[j][19:16]][rt[j][15:12]]) begin
                ovr(rt[j][11:8], rt[j][7:4], pwm[rt[j][2:0]], 1'h0);
            end
        end
        pin = (~en & eo) | (en & (ep | ext));
        chk("pad_out", pad_out, eo);
        chk("pad_oe_n", pad_oe_n, en);
        chk("pad_pu", pad_pu, ep);
        chk("digital_in", port_zero_digital_in, pin & gt & ~oe);
        chk("adc_select", adc_pin_select, ~gt & 8'hB8);
        chk("uart_rx", uart_rx, mdl[2][7] ? pin[2] & gt[2] & ~oe[2] : port3_rx_in);
        chk("port1_alt", {port1_alt_en, port1_alt_val}, {e1, v1});
        chk("port3_alt", {port3_alt_en, port3_alt_val}, {e3, v3});
        chk("selects", {serial_pin_select, i2c_data_pin_select, i2c_clock_pin_select},
            {mdl[2][7], mdl[6][7:6]});
    endtask : check_all
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        #40000;
        failures++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        for (int k = 0; k < 7; k++) rdchk(k);
        check_all();
        apb(1'h1, 8'h81, 32'hFF, -1);
        chk("wr_err", err, 1'h1);
        apb(1'h0, 8'h81, 32'h0, -1);
        chk("rd_unmapped", rd, 32'h0);
        chk("rd_unmapped_err", err, 1'h1);
        // random registers and sources stress shared pins and both select values
        repeat (50) begin
            for (int k = 0; k < 7; k++) apb(1'h1, ia[k], rnd(), k);
            r = rnd();
            pwm <= r[7:0];
            ext <= r[15:8];
            {i2c_clock_out, i2c_master_en, port3_rx_in} <= r[18:16];
            repeat (3) @(posedge pclk);
            #1;
            check_all();
            for (int k = 0; k < 7; k++) rdchk(k);
        end
        tally_and_finish();
    end
endmodule : tb_pzr_port0
`default_nettype wire
